//--- verilog/aci_defines.svh
// register indices, reset values, ranges and timing constants
`ifndef ACI_DEFINES_SVH
`define ACI_DEFINES_SVH

// register indices; byte address is four times the index
`define ACI_IDX_OVR_MODE     16'h220F
`define ACI_IDX_TQ_SCALE     16'h2210
`define ACI_IDX_TQ_OFFSET    16'h2211
`define ACI_IDX_TQ_CLAMP     16'h2212
`define ACI_IDX_TQ_FILT      16'h2213
`define ACI_IDX_VEL_SCALE    16'h2214
`define ACI_IDX_VEL_OFFSET   16'h2215
`define ACI_IDX_VEL_CLAMP    16'h2216
`define ACI_IDX_VEL_FILT     16'h2217
`define ACI_IDX_TQ_STATUS    16'h2218
`define ACI_IDX_VEL_STATUS   16'h2219
`define ACI_IDX_OVR_STATUS   16'h221A

// reset values
`define ACI_RST_OVR_MODE     16'h0000
`define ACI_RST_SCALE        16'h0064
`define ACI_RST_OFFSET       16'h0000
`define ACI_RST_CLAMP        16'h0000
`define ACI_RST_FILT         16'h0002

// override modes and settings
`define ACI_OVR_OFF          2'h0
`define ACI_OVR_BIPOLAR      2'h1
`define ACI_OVR_UNIPOLAR     2'h2
`define ACI_OVR_MODE_MAX     16'h0002
`define ACI_TQ_LIMIT_ANALOG  4'h4

// arithmetic constants
`define ACI_MV_PER_V         32'sd1000
`define ACI_OVR_UNITY        32'sd1000
`define ACI_OVR_MAX          32'sd2000
`define ACI_OVR_MV_PER_STEP  32'sd10

// filter timing: tau unit 0.1 ms, default sample period 0.1 ms
`define ACI_TAU_UNIT_NS      100000
`define ACI_SAMPLE_NS        100000
`define ACI_CLK_NS           10

`endif

//--- verilog/aci_pkg.sv
// types shared by the analogue command conditioner
package aci_pkg;

  // apb request from the bus master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } aci_apb_req_t;

  // apb answer to the bus master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } aci_apb_rsp_t;

  // operating context from the drive sequencer
  typedef struct packed {
    logic       torque_op;
    logic       velocity_op;
    logic       index_op;
    logic [3:0] torque_limit_sel;
  } aci_mode_t;

  // apb phases as seen by the slave
  typedef enum logic [1:0] {
    ACI_IDLE,
    ACI_SETUP,
    ACI_ACCESS
  } aci_apb_state_t;

endpackage : aci_pkg

//--- verilog/aci_lpf.sv
// first-order low-pass stage, one update per input strobe
`timescale 1ns/1ps
`include "aci_defines.svh"

module aci_lpf #(
  parameter int W    = 16,
  parameter int FRAC = 8,
  parameter int TS   = 1
) (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  // sample in
  input  wire logic                en_i,
  input  wire logic signed [W-1:0] x_i,
  input  wire logic [15:0]         tau_i,
  // filtered out
  output logic signed [W-1:0]      y_o,
  output logic                     valid_o
);

  localparam int AW = W + FRAC;

  logic signed [AW-1:0] acc_q;
  logic signed [AW-1:0] acc_d;
  logic signed [AW:0]   err;
  logic signed [17:0]   den;
  logic signed [AW+17:0] step;
  logic                 valid_q;

  // gain ts/(tau+ts); tau of zero gives unity gain, i.e. pass-through
  // first-order update
  assign err   = (AW+1)'($signed(x_i) <<< FRAC) - (AW+1)'(acc_q);
  assign den   = $signed({2'b00, tau_i}) + 18'(TS);
  assign step  = ((AW+18)'(err) * (AW+18)'(TS)) / (AW+18)'(den);
  assign acc_d = AW'(acc_q + AW'(step));

  // state updates only on a sample strobe
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= en_i;
      if (en_i) begin
        acc_q <= acc_d;
      end
    end
  end

  assign y_o     = W'(acc_q >>> FRAC);
  assign valid_o = valid_q;

endmodule : aci_lpf

//--- verilog/aci_conditioner.sv
// analogue torque and velocity command conditioner with apb registers
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "aci_defines.svh"

module aci_conditioner
  import aci_pkg::*;
#(
  parameter int W      = 16,
  parameter int FRAC   = 8,
  parameter int TS     = `ACI_SAMPLE_NS / `ACI_TAU_UNIT_NS
) (
  // clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  // register bus
  input  wire aci_apb_req_t        apb_i,
  output aci_apb_rsp_t             apb_o,
  // drive operating context
  input  wire aci_mode_t           mode_i,
  // converter samples, millivolts, same clock
  input  wire logic                sample_valid_i,
  input  wire logic signed [W-1:0] torque_mv_i,
  input  wire logic signed [W-1:0] velocity_mv_i,
  // torque loop
  output logic signed [W-1:0]      torque_cmd_o,
  output logic                     torque_cmd_valid_o,
  output logic signed [W-1:0]      torque_limit_o,
  output logic                     torque_limit_en_o,
  // velocity loop
  output logic signed [W-1:0]      velocity_cmd_o,
  output logic                     velocity_cmd_valid_o,
  output logic [W-1:0]             override_o
);

  // ------------------------------------------------------------------
  // saturation helpers
  // ------------------------------------------------------------------

  localparam logic signed [39:0] SMAX = 40'sd32767;
  localparam logic signed [39:0] SMIN = -40'sd32768;

  // clip a wide signed value into the output width
  function automatic logic signed [W-1:0] sat_w(
    input logic signed [39:0] v
  );
    logic signed [39:0] c;
    c = v;
    if (v > SMAX) begin
      c = SMAX;
    end else if (v < SMIN) begin
      c = SMIN;
    end
    return W'(c);
  endfunction : sat_w

  // absolute value, wide enough that the most negative input is safe
  function automatic logic [39:0] abs_w(
    input logic signed [39:0] v
  );
    return (v < 0) ? 40'(-v) : 40'(v);
  endfunction : abs_w

  // ------------------------------------------------------------------
  // register bus slave
  // ------------------------------------------------------------------

  aci_apb_state_t    apb_state;
  logic [15:0]       ovr_mode_q;
  logic [15:0]       tq_scale_q;
  logic [15:0]       tq_offset_q;
  logic [15:0]       tq_clamp_q;
  logic [15:0]       tq_filt_q;
  logic [15:0]       vel_scale_q;
  logic [15:0]       vel_offset_q;
  logic [15:0]       vel_clamp_q;
  logic [15:0]       vel_filt_q;
  logic [31:0]       rdata_q;
  logic              err_q;
  logic [31:0]       rdata_d;
  logic              hit;
  logic [15:0]       idx;
  logic              setup;
  logic              wr;

  // index from the byte address; low two bits must be zero
  assign idx   = {2'b00, apb_i.paddr[15:2]};
  assign setup = (apb_state == ACI_SETUP);
  assign wr    = apb_i.psel && apb_i.penable && apb_i.pwrite && !err_q;

  // merge the two low byte lanes with the current contents
  function automatic logic [15:0] lane_mix(
    input logic [15:0] old
  );
    logic [15:0] n;
    n = old;
    if (apb_i.pstrb[0]) begin
      n[7:0] = apb_i.pwdata[7:0];
    end
    if (apb_i.pstrb[1]) begin
      n[15:8] = apb_i.pwdata[15:8];
    end
    return n;
  endfunction : lane_mix

  // phase tracker; its setup phase times the read-data and error capture
  assign apb_state = !apb_i.psel ? ACI_IDLE :
                     (apb_i.penable ? ACI_ACCESS : ACI_SETUP);

  // ------------------------------------------------------------------
  // conditioning datapath
  // ------------------------------------------------------------------

  logic signed [39:0] tq_diff;
  logic signed [39:0] tq_prod;
  logic signed [39:0] tq_pct;
  logic               tq_in_clamp;
  logic signed [W-1:0] tq_cmd_raw;
  logic signed [W-1:0] tq_lim_raw;
  logic signed [39:0] vel_diff;
  logic signed [39:0] vel_rpm;
  logic               vel_in_clamp;
  logic signed [W-1:0] vel_cmd_raw;
  logic signed [39:0] ovr_in;
  logic signed [39:0] ovr_lin;
  logic signed [39:0] ovr_pct;
  logic [W-1:0]       ovr_raw;

  // offset removed for both command and limit
  assign tq_diff = 40'($signed(torque_mv_i)) - 40'($signed(tq_offset_q));

  // product of volts and 0.1 percent per volt
  assign tq_prod = tq_diff * 40'($signed(tq_scale_q));
  assign tq_pct  = tq_prod / `ACI_MV_PER_V;

  // dead band on the corrected voltage
  assign tq_in_clamp = abs_w(tq_diff) <= 40'(tq_clamp_q);

  assign tq_cmd_raw = tq_in_clamp ? '0 : sat_w(tq_pct);
  assign tq_lim_raw = sat_w(tq_pct);

  // offset from the command input in velocity operation
  assign vel_diff = 40'($signed(velocity_mv_i))
                  - 40'($signed(vel_offset_q));

  // rpm per volt, millivolts divided back to volts
  assign vel_rpm = (vel_diff * 40'($signed(vel_scale_q)))
                 / `ACI_MV_PER_V;

  // zero speed band compared in rpm, the clamp register's unit
  assign vel_in_clamp = abs_w(vel_rpm) <= 40'(vel_clamp_q);
  assign vel_cmd_raw  = vel_in_clamp ? '0 : sat_w(vel_rpm);

  // offset applies to the override only in indexing operation
  assign ovr_in = mode_i.index_op ? vel_diff
                                  : 40'($signed(velocity_mv_i));

  // negative volts read as zero in unipolar mode
  assign ovr_lin = (ovr_mode_q[1:0] == `ACI_OVR_UNIPOLAR && ovr_in < 0)
                 ? 40'sd0 : ovr_in;

  // ten millivolts per 0.1 percent around unity
  assign ovr_pct = `ACI_OVR_UNITY + ovr_lin / `ACI_OVR_MV_PER_STEP;

  // mode 0 holds unity, clip to 0..200 percent otherwise
  assign ovr_raw =
    (ovr_mode_q[1:0] == `ACI_OVR_OFF) ? W'(`ACI_OVR_UNITY) :
    (ovr_pct < 0)                     ? '0 :
    (ovr_pct > `ACI_OVR_MAX)          ? W'(`ACI_OVR_MAX) :
                                        W'(ovr_pct);

  // ------------------------------------------------------------------
  // sample stage ahead of the filters
  // ------------------------------------------------------------------

  logic signed [W-1:0] tq_s_q;
  logic signed [W-1:0] vel_s_q;
  logic signed [W-1:0] tq_lim_q;
  logic [W-1:0]        ovr_q;
  logic                smp_q;

  // capture conditioned values once per converter sample
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tq_s_q   <= '0;
      vel_s_q  <= '0;
      tq_lim_q <= '0;
      ovr_q    <= W'(`ACI_OVR_UNITY);
      smp_q    <= 1'b0;
    end else begin
      smp_q <= sample_valid_i;
      if (sample_valid_i) begin
        tq_s_q   <= tq_cmd_raw;
        vel_s_q  <= vel_cmd_raw;
        tq_lim_q <= tq_lim_raw;
        ovr_q    <= ovr_raw;
      end
    end
  end

  // ------------------------------------------------------------------
  // command filters
  // ------------------------------------------------------------------

  logic signed [W-1:0] tq_f;
  logic signed [W-1:0] vel_f;
  logic                tq_fv;
  logic                vel_fv;

  aci_lpf #(
    .W    (W),
    .FRAC (FRAC),
    .TS   (TS)
  ) u_tq_lpf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .en_i      (smp_q),
    .x_i       (tq_s_q),
    .tau_i     (tq_filt_q),
    .y_o       (tq_f),
    .valid_o   (tq_fv)
  );

  aci_lpf #(
    .W    (W),
    .FRAC (FRAC),
    .TS   (TS)
  ) u_vel_lpf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .en_i      (smp_q),
    .x_i       (vel_s_q),
    .tau_i     (vel_filt_q),
    .y_o       (vel_f),
    .valid_o   (vel_fv)
  );

  // ------------------------------------------------------------------
  // outputs to the control loops
  // ------------------------------------------------------------------

  // commands are gated by the operating mode; filters keep running so
  // a mode change does not restart from a stale state
  assign torque_cmd_o         = mode_i.torque_op ? tq_f : '0;
  assign torque_cmd_valid_o   = tq_fv && mode_i.torque_op;
  assign velocity_cmd_o       = mode_i.velocity_op ? vel_f : '0;
  assign velocity_cmd_valid_o = vel_fv && mode_i.velocity_op;
  assign override_o           = ovr_q;
  assign torque_limit_o       = tq_lim_q;

  // analogue limit only outside torque operation with selector 4
  assign torque_limit_en_o = !mode_i.torque_op &&
    (mode_i.torque_limit_sel == `ACI_TQ_LIMIT_ANALOG);

  // ------------------------------------------------------------------
  // register read mux and address decode
  // ------------------------------------------------------------------

  // read data chosen in setup and registered for the access phase
  always_comb begin
    rdata_d = '0;
    hit     = 1'b1;
    unique case (idx)
      `ACI_IDX_OVR_MODE:   rdata_d[15:0] = ovr_mode_q;
      `ACI_IDX_TQ_SCALE:   rdata_d[15:0] = tq_scale_q;
      `ACI_IDX_TQ_OFFSET:  rdata_d[15:0] = tq_offset_q;
      `ACI_IDX_TQ_CLAMP:   rdata_d[15:0] = tq_clamp_q;
      `ACI_IDX_TQ_FILT:    rdata_d[15:0] = tq_filt_q;
      `ACI_IDX_VEL_SCALE:  rdata_d[15:0] = vel_scale_q;
      `ACI_IDX_VEL_OFFSET: rdata_d[15:0] = vel_offset_q;
      `ACI_IDX_VEL_CLAMP:  rdata_d[15:0] = vel_clamp_q;
      `ACI_IDX_VEL_FILT:   rdata_d[15:0] = vel_filt_q;
      `ACI_IDX_TQ_STATUS:  rdata_d[15:0] = 16'(tq_f);
      `ACI_IDX_VEL_STATUS: rdata_d[15:0] = 16'(vel_f);
      `ACI_IDX_OVR_STATUS: rdata_d[15:0] = 16'(ovr_q);
      default:             hit           = 1'b0;
    endcase
    if (apb_i.paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end
  end

  // latch answer and decode result during the setup cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= apb_i.pwrite ? 32'h0000_0000 : rdata_d;
      err_q   <= !hit || (apb_i.pwrite && idx >= `ACI_IDX_TQ_STATUS);
    end
  end

  // zero wait states; error for unmapped or read-only targets
  assign apb_o.pready  = 1'b1;
  assign apb_o.pslverr = apb_i.psel && apb_i.penable && err_q;
  assign apb_o.prdata  = rdata_q;

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------

  // settings register file; writes land at the access edge only
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ovr_mode_q   <= `ACI_RST_OVR_MODE;
      tq_scale_q   <= `ACI_RST_SCALE;
      tq_offset_q  <= `ACI_RST_OFFSET;
      tq_clamp_q   <= `ACI_RST_CLAMP;
      tq_filt_q    <= `ACI_RST_FILT;
      vel_scale_q  <= `ACI_RST_SCALE;
      vel_offset_q <= `ACI_RST_OFFSET;
      vel_clamp_q  <= `ACI_RST_CLAMP;
      vel_filt_q   <= `ACI_RST_FILT;
    end else if (wr) begin
      unique case (idx)
        // out-of-range modes are dropped, old mode kept
        `ACI_IDX_OVR_MODE: begin
          if (lane_mix(ovr_mode_q) <= `ACI_OVR_MODE_MAX) begin
            ovr_mode_q <= lane_mix(ovr_mode_q);
          end
        end
        `ACI_IDX_TQ_SCALE:   tq_scale_q   <= lane_mix(tq_scale_q);
        `ACI_IDX_TQ_OFFSET:  tq_offset_q  <= lane_mix(tq_offset_q);
        `ACI_IDX_TQ_CLAMP:   tq_clamp_q   <= lane_mix(tq_clamp_q);
        `ACI_IDX_TQ_FILT:    tq_filt_q    <= lane_mix(tq_filt_q);
        `ACI_IDX_VEL_SCALE:  vel_scale_q  <= lane_mix(vel_scale_q);
        `ACI_IDX_VEL_OFFSET: vel_offset_q <= lane_mix(vel_offset_q);
        `ACI_IDX_VEL_CLAMP:  vel_clamp_q  <= lane_mix(vel_clamp_q);
        `ACI_IDX_VEL_FILT:   vel_filt_q   <= lane_mix(vel_filt_q);
        default: begin
        end
      endcase
    end
  end

endmodule : aci_conditioner

//--- sim/aci_cond_monitor.sv
// port-level assertion checker for the analogue command conditioner
`timescale 1ns/1ps
module aci_cond_monitor
  import aci_pkg::*;
#(
  parameter int W = 16
) (
  // clock and reset
  input wire logic                clk_sys_i,
  input wire logic                resetn_i,
  // register bus and context
  input wire aci_apb_req_t        apb_i,
  input wire aci_apb_rsp_t        apb_o,
  input wire aci_mode_t           mode_i,
  // samples and loop outputs
  input wire logic                sample_valid_i,
  input wire logic signed [W-1:0] torque_mv_i,
  input wire logic signed [W-1:0] velocity_mv_i,
  input wire logic signed [W-1:0] torque_cmd_o,
  input wire logic                torque_cmd_valid_o,
  input wire logic signed [W-1:0] torque_limit_o,
  input wire logic                torque_limit_en_o,
  input wire logic signed [W-1:0] velocity_cmd_o,
  input wire logic                velocity_cmd_valid_o,
  input wire logic [W-1:0]        override_o
);
  // ----------------------------------------------------------------
  // properties, one clock domain
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_limit_en;
    torque_limit_en_o ==
      (!mode_i.torque_op && mode_i.torque_limit_sel == 4'h4);
  endproperty
  a_limit_en: assert property (p_limit_en)
    else $error("limit enable wrong");
  property p_tq_gate;
    !mode_i.torque_op |-> torque_cmd_o == '0;
  endproperty
  a_tq_gate: assert property (p_tq_gate)
    else $error("torque command outside torque operation");
  property p_vel_gate;
    !mode_i.velocity_op |-> velocity_cmd_o == '0;
  endproperty
  a_vel_gate: assert property (p_vel_gate)
    else $error("velocity command outside velocity operation");
  // a valid pulse must trace back to a sample two edges earlier
  property p_tq_valid;
    torque_cmd_valid_o |-> mode_i.torque_op && $past(sample_valid_i, 2);
  endproperty
  a_tq_valid: assert property (p_tq_valid)
    else $error("torque valid without sample");
  property p_vel_valid;
    velocity_cmd_valid_o |-> $past(sample_valid_i, 2);
  endproperty
  a_vel_valid: assert property (p_vel_valid)
    else $error("velocity valid without sample");
  property p_ovr_range;
    override_o <= 16'h07D0;
  endproperty
  a_ovr_range: assert property (p_ovr_range)
    else $error("override above 200 percent");
  property p_hold;
    !sample_valid_i |=> $stable(torque_limit_o) && $stable(override_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("limit or override moved without sample");
  property p_err_phase;
    apb_o.pslverr |-> apb_i.psel && apb_i.penable;
  endproperty
  a_err_phase: assert property (p_err_phase)
    else $error("slave error outside access phase");

  c_tq: cover property (torque_cmd_valid_o && velocity_cmd_valid_o);
  c_lim: cover property (torque_limit_en_o && sample_valid_i);
  c_err: cover property (apb_o.pslverr);
endmodule : aci_cond_monitor

bind aci_conditioner aci_cond_monitor #(.W(W)) u_aci_cond_monitor (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .apb_i(apb_i),
  .apb_o(apb_o), .mode_i(mode_i), .sample_valid_i(sample_valid_i),
  .torque_mv_i(torque_mv_i), .velocity_mv_i(velocity_mv_i),
  .torque_cmd_o(torque_cmd_o), .torque_cmd_valid_o(torque_cmd_valid_o),
  .torque_limit_o(torque_limit_o), .torque_limit_en_o(torque_limit_en_o),
  .velocity_cmd_o(velocity_cmd_o),
  .velocity_cmd_valid_o(velocity_cmd_valid_o), .override_o(override_o)
);

//--- sim/aci_adc_model.sv
// converter sample source, one strobe per bench request
`timescale 1ns/1ps
module aci_adc_model (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  // request from the bench
  input  wire logic               go_i,
  input  wire logic signed [15:0] tq_i,
  input  wire logic signed [15:0] vel_i,
  // sample stream
  output logic                    sample_valid_o,
  output logic signed [15:0]      torque_mv_o,
  output logic signed [15:0]      velocity_mv_o
);
  // data toggles outside the strobe so stale values never pass
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_valid_o <= 1'b0;
      torque_mv_o    <= '0;
      velocity_mv_o  <= '0;
    end else if (go_i) begin
      sample_valid_o <= 1'b1;
      torque_mv_o    <= tq_i;
      velocity_mv_o  <= vel_i;
    end else begin
      sample_valid_o <= 1'b0;
      torque_mv_o    <= ~torque_mv_o;
      velocity_mv_o  <= ~velocity_mv_o;
    end
  end
endmodule : aci_adc_model

//--- sim/analog_command_conditioner_test.sv
// self-checking bench for the analogue command conditioner
`timescale 1ns/1ps
`include "aci_defines.svh"
module analog_command_conditioner_test;
  import aci_pkg::*;
  logic                clk_sys_i, resetn_i, go, sv, tq_v, vel_v, lim_en;
  logic                er;
  logic [31:0]         rd;
  logic [15:0]         ovr;
  logic signed [15:0]  tq_set, vel_set, tq_mv, vel_mv, tq_c, tq_l, vel_c;
  aci_apb_req_t        apb_i;
  aci_apb_rsp_t        apb_o;
  aci_mode_t           mode_i;
  int                  errors, comparisons, md, off, sc, tcl, voff, vsc;
  int                  vcl, mv, vmv;
  bit                  top, vop, iop;
  logic [15:0] ridx [9] = '{`ACI_IDX_OVR_MODE, `ACI_IDX_TQ_SCALE,
    `ACI_IDX_TQ_OFFSET, `ACI_IDX_TQ_CLAMP, `ACI_IDX_TQ_FILT,
    `ACI_IDX_VEL_SCALE, `ACI_IDX_VEL_OFFSET, `ACI_IDX_VEL_CLAMP,
    `ACI_IDX_VEL_FILT};
  int rrst [9] = '{0, 100, 0, 0, 2, 100, 0, 0, 2};

  aci_conditioner u_aci_conditioner (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .apb_i(apb_i), .apb_o(apb_o), .mode_i(mode_i),
    .sample_valid_i(sv), .torque_mv_i(tq_mv), .velocity_mv_i(vel_mv),
    .torque_cmd_o(tq_c), .torque_cmd_valid_o(tq_v), .torque_limit_o(tq_l),
    .torque_limit_en_o(lim_en), .velocity_cmd_o(vel_c),
    .velocity_cmd_valid_o(vel_v), .override_o(ovr));
  aci_adc_model u_aci_adc_model (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .go_i(go), .tq_i(tq_set), .vel_i(vel_set),
    .sample_valid_o(sv), .torque_mv_o(tq_mv), .velocity_mv_o(vel_mv));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // reference arithmetic, integers truncating toward zero
  function automatic int sat(int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction : sat
  function automatic int f_tq(int x, int o, int s, int c, bit cl);
    int d;
    d = x - o;
    if (cl && d <= c && d >= -c) return 0;
    return sat(d * s / 1000);
  endfunction : f_tq
  function automatic int f_vel(int x, int o, int s, int c);
    int r;
    r = sat((x - o) * s / 1000);
    return (r <= c && r >= -c) ? 0 : r;
  endfunction : f_vel
  function automatic int f_ovr(int m, int x, int o, bit ix);
    int y;
    y = ix ? x - o : x;
    if (m == 0) return 1000;
    if (m == 2 && y < 0) y = 0;
    y = 1000 + y / 10;
    return y < 0 ? 0 : (y > 2000 ? 2000 : y);
  endfunction : f_ovr
  function automatic int rnd(int a);
    return int'($urandom_range(2 * a)) - a;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input int exp, string what);
    comparisons++;
    if (got !== exp[15:0]) begin
      errors++;
      $display("Error t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic apb(input bit wr, input logic [15:0] ix, input int wd);
    @(posedge clk_sys_i);
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite  <= wr;
    apb_i.paddr   <= {ix[13:0], 2'b00};
    apb_i.pwdata  <= {16'h0000, wd[15:0]};
    apb_i.pstrb   <= 4'hF;
    @(posedge clk_sys_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    er = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask : apb
  // one converter sample, outputs settled after the walk
  task automatic send(input int t, input int v);
    @(posedge clk_sys_i);
    go      <= 1'b1;
    tq_set  <= 16'(t);
    vel_set <= 16'(v);
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
  endtask : send
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (50000) @(posedge clk_sys_i);
    errors++;
    $display("Error t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    resetn_i = 1'b0;
    apb_i = '0;
    mode_i = '0;
    go = 1'b0;
    tq_set = '0;
    vel_set = '0;
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    void'($urandom(24));
    foreach (ridx[k]) begin
      apb(1'b0, ridx[k], 0);
      chk(rd[15:0], rrst[k], "reset value");
    end
    chk(ovr, 1000, "override after reset");
    $display("reset values done");
    // default filter constant, first update from a zero state
    mode_i <= '{torque_op: 1'b1, velocity_op: 1'b1, default: '0};
    send(5000, 5000);
    chk(tq_c, 166, "torque first step");
    chk(vel_c, 166, "velocity first step");
    $display("default filter done");
    apb(1'b1, `ACI_IDX_TQ_FILT, 0);
    apb(1'b1, `ACI_IDX_VEL_FILT, 0);
    apb(1'b1, `ACI_IDX_OVR_MODE, 2);
    apb(1'b1, `ACI_IDX_OVR_MODE, 3);
    apb(1'b0, `ACI_IDX_OVR_MODE, 0);
    chk(rd[15:0], 2, "mode above two kept out");
    apb(1'b1, 16'h2220, 5);
    chk({15'h0, er}, 1, "unmapped write");
    apb(1'b1, `ACI_IDX_TQ_STATUS, 5);
    chk({15'h0, er}, 1, "status write");
    $display("register access done");
    for (int i = 0; i < 40; i++) begin
      md = i % 3;
      off = rnd(1000);
      sc = rnd(1000);
      tcl = int'($urandom_range(1000));
      voff = rnd(1000);
      vsc = rnd(1000);
      vcl = int'($urandom_range(300));
      case (i)
        0: mv = -10000;
        1: mv = 10000;
        2: mv = 0;
        3: mv = off + tcl;
        4: mv = off + tcl + 1;
        default: mv = rnd(10000);
      endcase
      vmv = (i < 3) ? mv : rnd(10000);
      top = (i < 6) || $urandom_range(1);
      vop = $urandom_range(1);
      iop = $urandom_range(1);
      apb(1'b1, `ACI_IDX_OVR_MODE, md);
      apb(1'b1, `ACI_IDX_TQ_SCALE, sc);
      apb(1'b1, `ACI_IDX_TQ_OFFSET, off);
      apb(1'b1, `ACI_IDX_TQ_CLAMP, tcl);
      apb(1'b1, `ACI_IDX_VEL_SCALE, vsc);
      apb(1'b1, `ACI_IDX_VEL_OFFSET, voff);
      apb(1'b1, `ACI_IDX_VEL_CLAMP, vcl);
      mode_i <= '{torque_op: top, velocity_op: vop, index_op: iop,
                  torque_limit_sel: (i % 2) ? 4'h4 : 4'(i % 8)};
      send(mv, vmv);
      chk(tq_l, f_tq(mv, off, sc, 0, 0), "limit");
      chk(tq_c, top ? f_tq(mv, off, sc, tcl, 1) : 0, "torque");
      chk(vel_c, vop ? f_vel(vmv, voff, vsc, vcl) : 0, "vel");
      chk(ovr, f_ovr(md, vmv, voff, iop), "override");
      chk({15'h0, lim_en}, !top && (i % 2 || i % 8 == 4), "lim en");
    end
    // status registers mirror the last sample, filters pass-through
    apb(1'b0, `ACI_IDX_TQ_STATUS, 0);
    chk(rd[15:0], f_tq(mv, off, sc, tcl, 1), "torque status");
    apb(1'b0, `ACI_IDX_VEL_STATUS, 0);
    chk(rd[15:0], f_vel(vmv, voff, vsc, vcl), "vel status");
    apb(1'b0, `ACI_IDX_OVR_STATUS, 0);
    chk(rd[15:0], f_ovr(md, vmv, voff, iop), "override status");
    $display("conditioning loop done");
    finish_test();
  end
endmodule : analog_command_conditioner_test
